// ### logic/sps_port.sv
// Synchronous serial port: APB registers, SPI shifter, two-wire status.
// Assumes one clock; serial clock and select pins pass two-flop synchronisers.
//
// How it works
// - Selected slave with select control shifts and drives data out.
// - Select high releases data output two pclk cycles later, after the synchroniser, even mid byte.
// - Select high holds port logic in reset in that mode.
// - Port reset clears bit counter; select high or enable cleared.
// - Master clocks freeze in sleep, resume on run.
// - Master completion wakes only when interrupts enabled.
// - Slave shifts on external clock; 8 bits set flag.
// - Device reset disables port, aborts transfer.
// - SPI modes map to polarity and edge bits.
// - Status low six bits read-only, top two writable; controls writable.
// - Address register: own address, or low seven bits baud reload.
// - Completed byte goes to data buffer if not full, sets interrupt flag.
// - Buffer write loads shift register too in SPI modes.
// - Two-wire: sample bit set disables slew control.
// - Two-wire: edge bit enables bus input thresholds.
// - Two-wire slave: data-not-address flag shows last byte kind.
// - Stop/start flags show latest condition; cleared on reset/disable.
// - Slave read-write bit holds matched direction until start, stop, nack.
// - Master read-write bit shows transmit; OR with requests means active.
// - Ten-bit slave flags address rewrite.
// - Buffer full while buffer holds unconsumed byte.
// - SPI mode field decodes master rates and slave options.
// - Polarity bit sets serial clock idle level.
// - Buffer write in transfer ignored; sets sticky collision flag.
// - Two-wire mode field decodes slave and master codes.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
module sps_port
   import sps_pkg::*;
(
   input wire logic pclk, // APB clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire sps_pin_in_s pins_in, // Serial pin inputs
   output sps_pin_out_s pins_out, // Serial pin outputs
   input wire logic timer_tick, // Timer pulse for timer-rate master
   input wire logic sleep_mode, // Device is in sleep
   input wire sps_tw_evt_s tw_evt, // Two-wire engine events
   output sps_tw_cfg_s tw_cfg, // Two-wire configuration
   output logic port_interrupt_flag, // Port interrupt flag
   output logic wake_request // Wake request
);
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [1:0] stat_hi_reg;
   logic [7:0] addr_reg;
   logic [7:0] buf_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic busy_reg;
   logic bf_reg;
   logic flag_reg;
   logic ien_reg;
   logic dna_reg;
   logic stop_reg;
   logic start_reg;
   logic rw_reg;
   logic ua_reg;
   logic out_bit_reg;
   logic sclk_reg;
   logic [4:0] div_reg;
   logic [31:0] rdata_reg;
   logic [1:0] sclk_sync_reg;
   logic sclk_prev_reg;
   logic [1:0] ss_sync_reg;
   logic sdi_reg;
   logic wake_reg;

   logic port_en, clock_polarity_bit, cke;
   logic [3:0] mode;
   logic spi_master, spi_slave, ss_ctrl, tw_mode, tw_master, tw_slave, tw_ten;
   logic ss_reset, ss_active;
   logic lead_edge, trail_edge, sample_edge, drive_edge;
   logic done, sclk_tick, master_run;
   logic [4:0] half_div;
   logic wr_acc, rd_acc, wr_data, rd_data, wr_ctrl1, wr_ctrl2, wr_stat, wr_addr, wr_wake;
   logic mapped, collide, rx_done, tw_rx_done;
   logic [7:0] rx_byte;
   logic [7:0] stat_val;

   assign port_en = ctrl1_reg[SPS_C1_EN];
   assign clock_polarity_bit = ctrl1_reg[SPS_C1_CKP];
   assign cke = stat_hi_reg[0];
   assign mode = ctrl1_reg[3:0];

   // Mode field decode
   always_comb begin
      spi_master = 1'b0;
      spi_slave = 1'b0;
      ss_ctrl = 1'b0;
      tw_master = 1'b0;
      tw_slave = 1'b0;
      tw_ten = 1'b0;
      half_div = SPS_HALF_DIV4;
      unique case (mode)
         SPS_M_SPI_M4: spi_master = 1'b1;
         SPS_M_SPI_M16: begin
            spi_master = 1'b1;
            half_div = SPS_HALF_DIV16;
         end
         SPS_M_SPI_M64: begin
            spi_master = 1'b1;
            half_div = SPS_HALF_DIV64;
         end
         SPS_M_SPI_MTMR: spi_master = 1'b1;
         SPS_M_SPI_SSS: begin
            spi_slave = 1'b1;
            ss_ctrl = 1'b1;
         end
         SPS_M_SPI_SNS: spi_slave = 1'b1;
         SPS_M_TW_S7, SPS_M_TW_S7I: tw_slave = 1'b1;
         SPS_M_TW_S10, SPS_M_TW_S10I: begin
            tw_slave = 1'b1;
            tw_ten = 1'b1;
         end
         SPS_M_TW_MST, SPS_M_TW_FWM: tw_master = 1'b1;
         default: ;
      endcase
   end
   assign tw_mode = tw_master | tw_slave;

   // Select reset and activity
   assign ss_reset = !port_en || (ss_ctrl && ss_sync_reg[1]);
   assign ss_active = spi_slave && port_en && !(ss_ctrl && ss_sync_reg[1]);

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_sync_reg <= 2'b00;
         sclk_prev_reg <= 1'b0;
         ss_sync_reg <= 2'b11;
         sdi_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], pins_in.sclk_in};
         sclk_prev_reg <= sclk_sync_reg[1];
         ss_sync_reg <= {ss_sync_reg[0], pins_in.ss_n};
         sdi_reg <= pins_in.serial_data_input;
      end
   end

   // Master clock generator, frozen in sleep
   assign master_run = spi_master && port_en && busy_reg && !sleep_mode;
   assign sclk_tick = master_run && !(bit_cnt_reg == SPS_BITS && sclk_reg == clock_polarity_bit) &&
      ((mode == SPS_M_SPI_MTMR) ? timer_tick : (div_reg == half_div));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 5'd0;
         sclk_reg <= 1'b0;
      end else if (!spi_master || !busy_reg) begin
         div_reg <= 5'd0;
         sclk_reg <= clock_polarity_bit;
      end else if (master_run) begin
         div_reg <= (div_reg == half_div) ? 5'd0 : div_reg + 5'd1;
         if (sclk_tick)
            sclk_reg <= !sclk_reg;
      end
   end

   // Edges against idle level
   always_comb begin
      lead_edge = 1'b0;
      trail_edge = 1'b0;
      if (spi_master) begin
         lead_edge = sclk_tick && (sclk_reg == clock_polarity_bit);
         trail_edge = sclk_tick && (sclk_reg != clock_polarity_bit);
      end else if (ss_active) begin
         lead_edge = (sclk_prev_reg == clock_polarity_bit) && (sclk_sync_reg[1] != clock_polarity_bit);
         trail_edge = (sclk_prev_reg != clock_polarity_bit) && (sclk_sync_reg[1] == clock_polarity_bit);
      end
   end
   // Edge bit set: drive on trailing, sample on leading
   assign sample_edge = cke ? lead_edge : trail_edge;
   assign drive_edge = cke ? trail_edge : lead_edge;

   assign done = (bit_cnt_reg == SPS_BITS) && (spi_slave || (sclk_reg == clock_polarity_bit));
   assign rx_done = port_en && !ss_reset && done;
   assign rx_byte = shift_reg;
   assign tw_rx_done = port_en && tw_mode && tw_evt.byte_done;

   // APB decode
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr == SPS_OFS_DATA) || (paddr == SPS_OFS_CTRL1) || (paddr == SPS_OFS_STAT) ||
      (paddr == SPS_OFS_CTRL2) || (paddr == SPS_OFS_ADDR) || (paddr == SPS_OFS_WAKE);
   assign wr_data = wr_acc && paddr == SPS_OFS_DATA;
   assign rd_data = rd_acc && paddr == SPS_OFS_DATA;
   assign wr_ctrl1 = wr_acc && paddr == SPS_OFS_CTRL1;
   assign wr_ctrl2 = wr_acc && paddr == SPS_OFS_CTRL2;
   assign wr_stat = wr_acc && paddr == SPS_OFS_STAT;
   assign wr_addr = wr_acc && paddr == SPS_OFS_ADDR;
   assign wr_wake = wr_acc && paddr == SPS_OFS_WAKE;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_reg;

   assign collide = busy_reg || (spi_slave && bit_cnt_reg != 4'd0) || tw_evt.tx_active;

   // Control registers; hardware set and clear win over writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_reg <= SPS_RST_CTRL1;
         ctrl2_reg <= SPS_RST_CTRL2;
         stat_hi_reg <= SPS_RST_STAT[7:6];
         addr_reg <= SPS_RST_ADDR;
      end else begin
         if (wr_ctrl1)
            ctrl1_reg <= pwdata[7:0];
         if (wr_data && collide && port_en)
            ctrl1_reg[SPS_C1_WRITE_COLLISION_FLAG] <= 1'b1;
         if ((rx_done || tw_rx_done) && bf_reg)
            ctrl1_reg[SPS_C1_OVF] <= 1'b1;
         if (wr_stat)
            stat_hi_reg <= pwdata[7:6];
         if (wr_addr)
            addr_reg <= pwdata[7:0];
         if (wr_ctrl2)
            ctrl2_reg <= pwdata[7:0];
         if (tw_evt.seq_done) begin
            ctrl2_reg[SPS_C2_ACK] <= 1'b0;
            ctrl2_reg[SPS_C2_RCV] <= 1'b0;
            ctrl2_reg[SPS_C2_STOP] <= 1'b0;
            ctrl2_reg[SPS_C2_RST] <= 1'b0;
            ctrl2_reg[SPS_C2_START] <= 1'b0;
         end
      end
   end

   // Shifter and bit counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'd0;
         busy_reg <= 1'b0;
         out_bit_reg <= 1'b0;
      end else if (ss_reset) begin
         bit_cnt_reg <= 4'd0;
         busy_reg <= 1'b0;
         if (wr_data && !tw_mode) begin
            shift_reg <= pwdata[7:0];
            out_bit_reg <= pwdata[7];
         end
      end else if (done) begin
         bit_cnt_reg <= 4'd0;
         busy_reg <= 1'b0;
      end else if (wr_data && !collide && !tw_mode) begin
         shift_reg <= pwdata[7:0];
         out_bit_reg <= pwdata[7];
         busy_reg <= spi_master;
      end else begin
         if (sample_edge && bit_cnt_reg != SPS_BITS) begin
            shift_reg <= {shift_reg[6:0], sdi_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
         end
         if (drive_edge)
            out_bit_reg <= shift_reg[7];
      end
   end

   // Buffer, full flag, interrupt flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_reg <= 8'h00;
         bf_reg <= 1'b0;
         flag_reg <= 1'b0;
         ien_reg <= 1'b0;
      end else begin
         if (wr_wake) begin
            flag_reg <= pwdata[SPS_WK_FLAG];
            ien_reg <= pwdata[SPS_WK_IEN];
         end
         if (rd_data)
            bf_reg <= 1'b0;
         if (wr_data && !collide) begin
            buf_reg <= pwdata[7:0];
            bf_reg <= tw_mode;
         end
         if (rx_done) begin
            flag_reg <= 1'b1;
            if (!bf_reg) begin
               buf_reg <= rx_byte;
               bf_reg <= 1'b1;
            end
         end
         if (tw_rx_done) begin
            flag_reg <= 1'b1;
            if (!bf_reg) begin
               buf_reg <= tw_evt.rx_byte;
               bf_reg <= 1'b1;
            end
         end
         if (port_en && tw_slave && tw_evt.addr_match)
            flag_reg <= 1'b1;
      end
   end

   // Two-wire status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dna_reg <= 1'b0;
         stop_reg <= 1'b0;
         start_reg <= 1'b0;
         rw_reg <= 1'b0;
         ua_reg <= 1'b0;
      end else if (!port_en || !tw_mode) begin
         stop_reg <= 1'b0;
         start_reg <= 1'b0;
         dna_reg <= 1'b0;
         rw_reg <= 1'b0;
         ua_reg <= 1'b0;
      end else begin
         if (tw_evt.start_det) begin
            start_reg <= 1'b1;
            stop_reg <= 1'b0;
         end
         if (tw_evt.stop_det) begin
            stop_reg <= 1'b1;
            start_reg <= 1'b0;
         end
         if (tw_slave && tw_evt.byte_done)
            dna_reg <= tw_evt.is_data;
         if (tw_evt.start_det || tw_evt.stop_det || tw_evt.nack_det)
            rw_reg <= 1'b0;
         if (tw_slave && tw_evt.addr_match)
            rw_reg <= tw_evt.rw_bit;
         if (tw_ten && tw_evt.ua_req)
            ua_reg <= 1'b1;
         else if (wr_addr)
            ua_reg <= 1'b0;
      end
   end

   // Status readback
   always_comb begin
      stat_val = 8'h00;
      stat_val[SPS_ST_SMP] = stat_hi_reg[1];
      stat_val[SPS_ST_CKE] = stat_hi_reg[0];
      stat_val[SPS_ST_DNA] = tw_slave ? dna_reg : 1'b0;
      stat_val[SPS_ST_STOP] = stop_reg;
      stat_val[SPS_ST_START] = start_reg;
      stat_val[SPS_ST_RW] = tw_master ? tw_evt.tx_active : rw_reg;
      stat_val[SPS_ST_UA] = ua_reg;
      stat_val[SPS_ST_BF] = bf_reg;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rdata_reg <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            SPS_OFS_DATA: rdata_reg <= {24'h000000, buf_reg};
            SPS_OFS_CTRL1: rdata_reg <= {24'h000000, ctrl1_reg};
            SPS_OFS_STAT: rdata_reg <= {24'h000000, stat_val};
            SPS_OFS_CTRL2: rdata_reg <= {24'h000000, ctrl2_reg};
            SPS_OFS_ADDR: rdata_reg <= {24'h000000, addr_reg};
            SPS_OFS_WAKE: rdata_reg <= {30'h00000000, ien_reg, flag_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Wake request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wake_reg <= 1'b0;
      else
         wake_reg <= flag_reg && ien_reg;
   end

   assign port_interrupt_flag = flag_reg;
   assign wake_request = wake_reg;
   assign pins_out.sclk_out = sclk_reg;
   assign pins_out.sclk_oe = port_en && spi_master;
   assign pins_out.serial_data_output = out_bit_reg;
   assign pins_out.sdo_oe = port_en && (spi_master || ss_active);
   assign tw_cfg.slew_ctrl_en = !stat_hi_reg[1];
   assign tw_cfg.smbus_thr_en = tw_mode && stat_hi_reg[0];
   assign tw_cfg.baud_reload = addr_reg[6:0];
   assign tw_cfg.own_address = addr_reg;
   assign tw_cfg.port_active = tw_master && (tw_evt.tx_active || ctrl2_reg[SPS_C2_ACK] ||
      ctrl2_reg[SPS_C2_RCV] || ctrl2_reg[SPS_C2_STOP] || ctrl2_reg[SPS_C2_RST] ||
      ctrl2_reg[SPS_C2_START]);
endmodule // sps_port

// ### logic/sps_pkg.sv
// Package for the synchronous serial port: map, fields, codes, structs.
// Used by sps_port, its bound checker and its bench.
package sps_pkg;
   // APB byte addresses
   localparam logic [7:0] SPS_OFS_DATA = 8'h00;
   localparam logic [7:0] SPS_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] SPS_OFS_STAT = 8'h08;
   localparam logic [7:0] SPS_OFS_CTRL2 = 8'h0c;
   localparam logic [7:0] SPS_OFS_ADDR = 8'h10;
   localparam logic [7:0] SPS_OFS_WAKE = 8'h14;

   // Reset values
   localparam logic [7:0] SPS_RST_CTRL1 = 8'h00;
   localparam logic [7:0] SPS_RST_CTRL2 = 8'h00;
   localparam logic [7:0] SPS_RST_STAT = 8'h00;
   localparam logic [7:0] SPS_RST_ADDR = 8'h00;

   // Control one fields
   localparam int SPS_C1_WRITE_COLLISION_FLAG = 7;
   localparam int SPS_C1_OVF = 6;
   localparam int SPS_C1_EN = 5;
   localparam int SPS_C1_CKP = 4;
   // Status fields
   localparam int SPS_ST_SMP = 7;
   localparam int SPS_ST_CKE = 6;
   localparam int SPS_ST_DNA = 5;
   localparam int SPS_ST_STOP = 4;
   localparam int SPS_ST_START = 3;
   localparam int SPS_ST_RW = 2;
   localparam int SPS_ST_UA = 1;
   localparam int SPS_ST_BF = 0;
   // Control two request bits
   localparam int SPS_C2_ACK = 4;
   localparam int SPS_C2_RCV = 3;
   localparam int SPS_C2_STOP = 2;
   localparam int SPS_C2_RST = 1;
   localparam int SPS_C2_START = 0;
   // Wake fields
   localparam int SPS_WK_FLAG = 0;
   localparam int SPS_WK_IEN = 1;

   // Mode codes
   localparam logic [3:0] SPS_M_SPI_M4 = 4'h0;
   localparam logic [3:0] SPS_M_SPI_M16 = 4'h1;
   localparam logic [3:0] SPS_M_SPI_M64 = 4'h2;
   localparam logic [3:0] SPS_M_SPI_MTMR = 4'h3;
   localparam logic [3:0] SPS_M_SPI_SSS = 4'h4;
   localparam logic [3:0] SPS_M_SPI_SNS = 4'h5;
   localparam logic [3:0] SPS_M_TW_S7 = 4'h6;
   localparam logic [3:0] SPS_M_TW_S10 = 4'h7;
   localparam logic [3:0] SPS_M_TW_MST = 4'h8;
   localparam logic [3:0] SPS_M_TW_FWM = 4'hb;
   localparam logic [3:0] SPS_M_TW_S7I = 4'he;
   localparam logic [3:0] SPS_M_TW_S10I = 4'hf;

   // Last divider count of a master half period, pclk cycles minus one
   localparam logic [4:0] SPS_HALF_DIV4 = 5'd1;
   localparam logic [4:0] SPS_HALF_DIV16 = 5'd7;
   localparam logic [4:0] SPS_HALF_DIV64 = 5'd31;
   localparam logic [3:0] SPS_BITS = 4'd8;

   typedef struct packed {
      logic sclk_in;
      logic ss_n;
      logic serial_data_input;
   } sps_pin_in_s;

   typedef struct packed {
      logic sclk_out;
      logic sclk_oe;
      logic serial_data_output;
      logic sdo_oe;
   } sps_pin_out_s;

   // Two-wire engine events
   typedef struct packed {
      logic start_det;
      logic stop_det;
      logic nack_det;
      logic addr_match;
      logic rw_bit;
      logic byte_done;
      logic is_data;
      logic [7:0] rx_byte;
      logic ua_req;
      logic tx_active;
      logic seq_done;
   } sps_tw_evt_s;

   typedef struct packed {
      logic slew_ctrl_en;
      logic smbus_thr_en;
      logic [6:0] baud_reload;
      logic [7:0] own_address;
      logic port_active;
   } sps_tw_cfg_s;
endpackage

// ### tb/sps_port_asserts.sv
// Checker for sps_port port timing.
// Bound into sps_port; shadows software-written bits.
`timescale 1ns/1ns
module sps_port_asserts
   import sps_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Bus select
   input wire logic penable, // Bus enable
   input wire logic pwrite, // Bus direction
   input wire logic [7:0] paddr, // Bus address
   input wire logic [31:0] pwdata, // Bus write data
   input wire logic [31:0] prdata, // Bus read data
   input wire sps_pin_in_s pins_in, // Serial inputs
   input wire sps_pin_out_s pins_out, // Serial outputs
   input wire sps_tw_cfg_s tw_cfg, // Two-wire config
   input wire logic port_interrupt_flag, // Port flag
   input wire logic wake_request // Wake request
);
   logic [7:0] c1, st, ad;
   logic ien;
   wire wr = psel && penable && pwrite;
   wire rd_st = psel && penable && !pwrite && paddr == SPS_OFS_STAT;
   wire sss = c1[SPS_C1_EN] && c1[3:0] == SPS_M_SPI_SSS;
   wire tw_m = c1[3:0] inside {SPS_M_TW_S7, SPS_M_TW_S10, SPS_M_TW_MST, SPS_M_TW_FWM, SPS_M_TW_S7I, SPS_M_TW_S10I};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of software-owned bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c1 <= 8'h00;
         st <= 8'h00;
         ad <= 8'h00;
         ien <= 1'b0;
      end else if (wr) begin
         if (paddr == SPS_OFS_CTRL1) c1 <= pwdata[7:0];
         if (paddr == SPS_OFS_STAT) st <= pwdata[7:0];
         if (paddr == SPS_OFS_ADDR) ad <= pwdata[7:0];
         if (paddr == SPS_OFS_WAKE) ien <= pwdata[SPS_WK_IEN];
      end
   end
   a_slave_drive: assert property ((sss && !pins_in.ss_n) [*5] |-> pins_out.sdo_oe)
      else $error("data out not driven");
   a_slave_release: assert property (sss && $rose(pins_in.ss_n) |-> ##[1:4] !pins_out.sdo_oe)
      else $error("data out still driven");
   a_clk_idle: assert property (wr && paddr == SPS_OFS_CTRL1 && pwdata[5] && pwdata[3:2] == 2'b00
      |=> ##1 pins_out.sclk_out == c1[SPS_C1_CKP] && pins_out.sclk_oe) else $error("clock idle level");
   a_fast_half: assert property (c1[SPS_C1_EN] && c1[3:0] == SPS_M_SPI_M4 && $stable(c1)
      && $changed(pins_out.sclk_out) |=> $stable(pins_out.sclk_out)) else $error("half period short");
   a_wake_follow: assert property (wake_request == $past(port_interrupt_flag && ien))
      else $error("wake request wrong");
   a_slew_sel: assert property (tw_cfg.slew_ctrl_en == !st[SPS_ST_SMP])
      else $error("slew select wrong");
   a_thr_sel: assert property (tw_cfg.smbus_thr_en == (tw_m && st[SPS_ST_CKE]))
      else $error("threshold select wrong");
   a_addr_view: assert property (tw_cfg.baud_reload == ad[6:0] && tw_cfg.own_address == ad)
      else $error("address view wrong");
   a_stat_top: assert property (rd_st |-> prdata[7:6] == st[7:6] && prdata[31:8] == 24'h0)
      else $error("status top bits wrong");
   a_flags_off: assert property (rd_st && !c1[SPS_C1_EN] |-> prdata[4:3] == 2'b00)
      else $error("bus flags not clear");
   a_reset_quiet: assert property ($rose(presetn) |-> !pins_out.sdo_oe && !pins_out.sclk_oe)
      else $error("port active after reset");
   c_wake: cover property ($rose(wake_request));
   c_drive: cover property ($rose(pins_out.sdo_oe));
   c_abort: cover property (sss && $rose(pins_in.ss_n));
endmodule // sps_port_asserts
bind sps_port sps_port_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pins_in(pins_in), .pins_out(pins_out),
   .tw_cfg(tw_cfg), .port_interrupt_flag(port_interrupt_flag), .wake_request(wake_request));

// ### tb/sps_far_master.sv
// Far-end SPI master model for slave tests.
// Paced by the bench clock.
`timescale 1ns/1ns
module sps_far_master (
   input wire logic clk, // Bench clock for pacing
   output logic sclk, // Serial clock to the port
   output logic ss_n, // Select, active low
   output logic data_to_port, // Serial data toward the port
   input wire logic data_from_port // Serial data from the port
);
   parameter int HALF = 8;
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      data_to_port = 1'b1;
   end
   // Shifts nb bits MSB first; fewer than 8 aborts mid byte
   task automatic xfer(input logic [7:0] tx, input logic pol, input logic cke, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk);
      sclk <= pol;
      ss_n <= 1'b0;
      repeat (HALF) @(posedge clk);
      for (int i = 7; i > 7 - nb; i--) begin
         if (cke) begin
            data_to_port <= tx[i];
            repeat (HALF) @(posedge clk);
            rx[i] = data_from_port;
         end
         sclk <= ~pol;
         if (!cke) data_to_port <= tx[i];
         repeat (HALF) @(posedge clk);
         if (!cke) rx[i] = data_from_port;
         sclk <= pol;
         if (!cke) repeat (HALF) @(posedge clk);
      end
      repeat (HALF) @(posedge clk);
      ss_n <= 1'b1;
      // Released line shows no stale bit
      data_to_port <= ~data_to_port;
   endtask
endmodule // sps_far_master

// ### tb/sps_port_tb.sv
// Self-checking bench for sps_port.
// Drives APB, loopback runs and a far-end master.
`timescale 1ns/1ns
module sps_port_tb
   import sps_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_tick = 1'b0;
   logic sleep_mode = 1'b0, lpb = 1'b0, pready, pslverr, perr, port_interrupt_flag, wake_request;
   logic m_sclk, m_ss_n, m_data;
   logic [7:0] paddr = 8'h00, rx;
   logic [2:0] tdiv = 3'h0;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   sps_pin_in_s pins_in;
   sps_pin_out_s pins_out;
   sps_tw_evt_s tw_evt = '0;
   sps_tw_cfg_s tw_cfg;
   int n_errors = 0, n_tests = 0;
   assign pins_in = {m_sclk, m_ss_n, lpb ? pins_out.serial_data_output : m_data};
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      tdiv <= tdiv + 3'h1;
      timer_tick <= tdiv == 3'h0;
   end
   sps_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
      .timer_tick(timer_tick), .sleep_mode(sleep_mode), .tw_evt(tw_evt), .tw_cfg(tw_cfg),
      .port_interrupt_flag(port_interrupt_flag), .wake_request(wake_request));
   sps_far_master u_far (.clk(pclk), .sclk(m_sclk), .ss_n(m_ss_n), .data_to_port(m_data),
      .data_from_port(pins_out.sdo_oe ? pins_out.serial_data_output : 1'b1));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic wait_flag();
      for (int k = 0; k < 400; k++) begin
         apb(1'b0, SPS_OFS_WAKE, 8'h00);
         if (rv[SPS_WK_FLAG] === 1'b1) break;
      end
      chk(rv[SPS_WK_FLAG], 1'b1);
   endtask
   task automatic t_regs();
      for (int i = 1; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 8'h00);
         chk(rv, 32'h0);
      end
      apb(1'b1, SPS_OFS_STAT, 8'hff);
      apb(1'b0, SPS_OFS_STAT, 8'h00);
      chk(rv, 32'hc0);
      apb(1'b1, SPS_OFS_CTRL2, 8'h1f);
      apb(1'b0, SPS_OFS_CTRL2, 8'h00);
      chk(rv, 32'h1f);
      apb(1'b1, SPS_OFS_CTRL2, 8'h00);
      apb(1'b1, SPS_OFS_CTRL1, 8'h1b);
      apb(1'b0, SPS_OFS_CTRL1, 8'h00);
      chk(rv, 32'h1b);
      apb(1'b1, SPS_OFS_CTRL1, 8'h00);
      apb(1'b1, SPS_OFS_ADDR, 8'hd3);
      chk(tw_cfg.baud_reload, 7'h53);
      apb(1'b0, 8'h40, 8'h00);
      chk({rv[7:0], perr}, 9'h001);
      apb(1'b1, SPS_OFS_STAT, 8'h00);
      $display("registers done");
   endtask
   task automatic t_master();
      lpb <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, SPS_OFS_STAT, {~i[0], 7'h00});
         apb(1'b1, SPS_OFS_CTRL1, {3'b001, i[1], 4'(i)});
         apb(1'b1, SPS_OFS_WAKE, 8'h02);
         repeat (4) @(posedge pclk);
         chk(pins_out.sclk_out, i[1]);
         apb(1'b1, SPS_OFS_DATA, 8'h96 ^ 8'(i));
         wait_flag();
         chk(wake_request, 1'b1);
         apb(1'b0, SPS_OFS_STAT, 8'h00);
         chk(rv[SPS_ST_BF], 1'b1);
         apb(1'b0, SPS_OFS_DATA, 8'h00);
         chk(rv, 32'h96 ^ i);
         apb(1'b0, SPS_OFS_STAT, 8'h00);
         chk(rv[SPS_ST_BF], 1'b0);
      end
      $display("master modes done");
   endtask
   task automatic t_sleep();
      logic v;
      apb(1'b1, SPS_OFS_CTRL1, 8'h21);
      apb(1'b1, SPS_OFS_WAKE, 8'h00);
      apb(1'b1, SPS_OFS_DATA, 8'h3c);
      apb(1'b1, SPS_OFS_DATA, 8'hff);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      v = pins_out.sclk_out;
      repeat (40) @(posedge pclk);
      chk(pins_out.sclk_out, v);
      apb(1'b0, SPS_OFS_WAKE, 8'h00);
      chk(rv, 32'h0);
      sleep_mode <= 1'b0;
      wait_flag();
      chk(wake_request, 1'b0);
      apb(1'b0, SPS_OFS_CTRL1, 8'h00);
      chk(rv, 32'ha1);
      apb(1'b0, SPS_OFS_DATA, 8'h00);
      chk(rv, 32'h3c);
      apb(1'b1, SPS_OFS_CTRL1, 8'h21);
      apb(1'b0, SPS_OFS_CTRL1, 8'h00);
      chk(rv, 32'h21);
      $display("sleep done");
   endtask
   task automatic t_slave();
      lpb <= 1'b0;
      apb(1'b1, SPS_OFS_STAT, 8'h40);
      apb(1'b1, SPS_OFS_CTRL1, 8'h24);
      apb(1'b1, SPS_OFS_WAKE, 8'h00);
      apb(1'b1, SPS_OFS_DATA, 8'h3c);
      u_far.xfer(8'ha5, 1'b0, 1'b1, 8, rx);
      chk(rx, 8'h3c);
      wait_flag();
      apb(1'b0, SPS_OFS_DATA, 8'h00);
      chk(rv, 32'ha5);
      apb(1'b1, SPS_OFS_WAKE, 8'h00);
      u_far.xfer(8'hff, 1'b0, 1'b1, 3, rx);
      repeat (10) @(posedge pclk);
      apb(1'b0, SPS_OFS_STAT, 8'h00);
      chk(rv, 32'h40);
      apb(1'b0, SPS_OFS_WAKE, 8'h00);
      chk(rv, 32'h0);
      u_far.xfer(8'h5a, 1'b0, 1'b1, 8, rx);
      wait_flag();
      apb(1'b0, SPS_OFS_DATA, 8'h00);
      chk(rv, 32'h5a);
      $display("slave done");
   endtask
   task automatic t_tw();
      logic [3:0] codes [6] = '{SPS_M_TW_S7, SPS_M_TW_S10, SPS_M_TW_MST, SPS_M_TW_FWM, SPS_M_TW_S7I, SPS_M_TW_S10I};
      foreach (codes[k]) begin
         apb(1'b1, SPS_OFS_CTRL1, {4'h2, codes[k]});
         chk(tw_cfg.smbus_thr_en, 1'b1);
      end
      apb(1'b1, SPS_OFS_CTRL1, 8'h26);
      for (int k = 0; k < 2; k++) begin
         tw_evt.start_det <= k == 0;
         tw_evt.stop_det <= k == 1;
         @(posedge pclk);
         tw_evt <= '0;
         apb(1'b0, SPS_OFS_STAT, 8'h00);
         chk(rv[4:3], k == 0 ? 2'b01 : 2'b10);
      end
      apb(1'b1, SPS_OFS_CTRL1, 8'h06);
      apb(1'b0, SPS_OFS_STAT, 8'h00);
      chk(rv[4:3], 2'b00);
      $display("two-wire done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_master();
      t_sleep();
      t_slave();
      t_tw();
      wrap_up();
   end
   // Run needs under 20000 cycles
   initial begin
      #1_000_000;
      n_errors++;
      wrap_up();
   end
endmodule // sps_port_tb
